// file: hw/atrc_top.sv
// aux and current trim registers, start/run control and wishbone slave for the three converters
`timescale 1ns/1ps
module atrc_top #(
   parameter int unsigned DLY_STEP_CYC = atrc_pkg::DLY_STEP_CYC,
   parameter int unsigned CS_T0_CYC    = atrc_pkg::CS_T0_CYC,
   parameter int unsigned CS_T1_CYC    = atrc_pkg::CS_T1_CYC,
   parameter int unsigned CS_T2_CYC    = atrc_pkg::CS_T2_CYC,
   parameter int unsigned CS_T3_CYC    = atrc_pkg::CS_T3_CYC
) (
   input  wire logic                 clk_i,
   input  wire logic                 rst_i,
   input  wire logic                 wb_cyc_i,
   input  wire logic                 wb_stb_i,
   input  wire logic                 wb_we_i,
   input  wire logic [15:0]          wb_adr_i,
   input  wire logic [3:0]           wb_sel_i,
   input  wire logic [31:0]          wb_dat_i,
   output logic      [31:0]          wb_dat_o,
   output logic                      wb_ack_o,
   input  wire atrc_pkg::atrc_trim_t otp_trim_i,
   input  wire logic                 main_pass_done_i,
   input  wire logic                 aux_pass_done_i,
   input  wire logic [4:0]           active_cell_count_i,
   input  wire logic [7:0]           gpio_adc_cfg_i,
   output atrc_pkg::atrc_trim_t      trim_o,
   output atrc_pkg::atrc_main_t      main_o,
   output atrc_pkg::atrc_aux_t       aux_o
);

   // ===========================================================
   // state
   typedef struct packed {
      logic                 ack;
      logic [31:0]          dat;
      logic                 load_pend;
      atrc_pkg::atrc_trim_t trim;
      logic [7:0]           filt;
      logic [7:0]           dly;
      logic [7:0]           mctl;
      logic [7:0]           ach;
      logic [7:0]           arun;
      atrc_pkg::atrc_seq_t  mseq;
      logic [15:0]          dly_cnt;
      logic [3:0]           mpass;
      logic [20:0]          cs_cnt;
      atrc_pkg::atrc_main_t main;
      logic [3:0]           apass;
      atrc_pkg::atrc_aux_t  aux;
   } atrc_state_t;

   atrc_state_t st_q;
   atrc_state_t st_d;

   // ===========================================================
   // helpers
   // code 7 is an alias, so the filter only ever sees seven settings
   function automatic logic [2:0] atrc_eff_cut(input logic [2:0] code);
      atrc_eff_cut = (code == atrc_pkg::CUT_ALIAS) ? atrc_pkg::CUT_ALIAS_TO : code;
   endfunction : atrc_eff_cut

   // undefined codes fall back to no delay
   function automatic logic [15:0] atrc_dly_cyc(input logic [5:0] code);
      if (code > atrc_pkg::DLY_MAX_CODE) begin
         atrc_dly_cyc = 16'h0000;
      end else begin
         atrc_dly_cyc = 16'(32'(code) * DLY_STEP_CYC);
      end
   endfunction : atrc_dly_cyc

   // reload value of the measurement timer, one less than the period
   function automatic logic [20:0] atrc_cs_reload(input logic [1:0] sel);
      case (sel)
         2'b00:   atrc_cs_reload = 21'(CS_T0_CYC - 1);
         2'b01:   atrc_cs_reload = 21'(CS_T1_CYC - 1);
         2'b10:   atrc_cs_reload = 21'(CS_T2_CYC - 1);
         default: atrc_cs_reload = 21'(CS_T3_CYC - 1);
      endcase
   endfunction : atrc_cs_reload

   // ===========================================================
   // bus decode
   logic        req;
   logic        wr;
   logic [13:0] idx;
   logic [7:0]  wbyte;
   logic        wr_main_go;
   logic        wr_aux_go;

   assign req        = wb_cyc_i & wb_stb_i;
   // writes land on the edge where ack is seen high, as the master expects
   assign wr         = req & wb_we_i & st_q.ack & wb_sel_i[0];
   assign idx        = wb_adr_i[15:2];
   assign wbyte      = wb_dat_i[7:0];
   assign wr_main_go = wr & (idx == atrc_pkg::IDX_MAIN_CTRL) & wbyte[atrc_pkg::MAIN_GO_BIT];
   assign wr_aux_go  = wr & (idx == atrc_pkg::IDX_AUX_RUN) & wbyte[atrc_pkg::AUX_GO_BIT];

   // ===========================================================
   // next state
   always_comb begin
      st_d                 = st_q;
      st_d.main.conv_start = 1'b0;
      st_d.main.cs_sample  = 1'b0;
      st_d.aux.start       = 1'b0;
      st_d.ack             = req & ~st_q.ack;
      st_d.dat             = 32'h0000_0000;

      // readback; go bits are never stored so they read 0
      if (req & ~wb_we_i & ~st_q.ack) begin
         if (idx == atrc_pkg::IDX_FILT_CFG) begin
            st_d.dat[7:0] = st_q.filt;
         end else if (idx == atrc_pkg::IDX_DLY_CFG) begin
            st_d.dat[7:0] = st_q.dly;
         end else if (idx == atrc_pkg::IDX_AUX_TRIM_LO) begin
            st_d.dat[7:0] = st_q.trim.aux_gain[7:0];
         end else if (idx == atrc_pkg::IDX_AUX_TRIM_HI) begin
            st_d.dat[7:0] = {st_q.trim.aux_gain[8], st_q.trim.aux_offset};
         end else if (idx == atrc_pkg::IDX_CS_TRIM_LO) begin
            st_d.dat[7:0] = st_q.trim.cs_gain[7:0];
         end else if (idx == atrc_pkg::IDX_CS_TRIM_HI) begin
            st_d.dat[7:0] = {st_q.trim.cs_gain[10:8], st_q.trim.cs_offset};
         end else if (idx == atrc_pkg::IDX_MAIN_CTRL) begin
            st_d.dat[7:0] = st_q.mctl;
         end else if (idx == atrc_pkg::IDX_AUX_CH) begin
            st_d.dat[7:0] = st_q.ach;
         end else if (idx == atrc_pkg::IDX_AUX_RUN) begin
            st_d.dat[7:0] = st_q.arun;
         end else if (idx == atrc_pkg::IDX_STATUS) begin
            st_d.dat[2:0] = {st_q.aux.run, st_q.mseq == atrc_pkg::SEQ_DELAY, st_q.main.run};
         end
      end

      // one-shot copy of the fused trim right after reset
      if (st_q.load_pend) begin
         st_d.trim      = otp_trim_i;
         st_d.load_pend = 1'b0;
      end

      // register writes, reserved bits masked off
      if (wr) begin
         if (idx == atrc_pkg::IDX_FILT_CFG) begin
            st_d.filt = wbyte & atrc_pkg::MASK_FILT;
         end else if (idx == atrc_pkg::IDX_DLY_CFG) begin
            st_d.dly = wbyte & atrc_pkg::MASK_DLY;
         end else if (idx == atrc_pkg::IDX_AUX_TRIM_LO) begin
            st_d.trim.aux_gain[7:0] = wbyte;
         end else if (idx == atrc_pkg::IDX_AUX_TRIM_HI) begin
            st_d.trim.aux_gain[8] = wbyte[7];
            st_d.trim.aux_offset  = wbyte[6:0];
         end else if (idx == atrc_pkg::IDX_CS_TRIM_LO) begin
            st_d.trim.cs_gain[7:0] = wbyte;
         end else if (idx == atrc_pkg::IDX_CS_TRIM_HI) begin
            st_d.trim.cs_gain[10:8] = wbyte[7:5];
            st_d.trim.cs_offset     = wbyte[4:0];
         end else if (idx == atrc_pkg::IDX_MAIN_CTRL) begin
            st_d.mctl = wbyte & atrc_pkg::MASK_MAIN;
         end else if (idx == atrc_pkg::IDX_AUX_CH) begin
            st_d.ach = wbyte & atrc_pkg::MASK_ACH;
         end else if (idx == atrc_pkg::IDX_AUX_RUN) begin
            st_d.arun = wbyte & atrc_pkg::MASK_ARUN;
         end
      end

      // main and current sequencer, one control for both converters
      case (st_q.mseq)
         atrc_pkg::SEQ_IDLE: begin
            st_d.main.run = 1'b0;
         end
         atrc_pkg::SEQ_DELAY: begin
            if (st_q.dly_cnt == 16'h0000) begin
               st_d.mseq            = atrc_pkg::SEQ_RUN;
               st_d.main.conv_start = 1'b1;
               st_d.cs_cnt          = atrc_sel_reload();
            end else begin
               st_d.dly_cnt = st_q.dly_cnt - 16'h0001;
            end
         end
         atrc_pkg::SEQ_RUN: begin
            // current converter paced by its measurement time
            if (st_q.cs_cnt == 21'h000000) begin
               st_d.main.cs_sample = 1'b1;
               st_d.cs_cnt         = atrc_sel_reload();
            end else begin
               st_d.cs_cnt = st_q.cs_cnt - 21'h000001;
            end
            if (main_pass_done_i && st_q.main.mode == atrc_pkg::MODE_SINGLE) begin
               if (st_q.mpass == atrc_pkg::MAIN_PASSES - 4'h1) begin
                  st_d.mseq     = atrc_pkg::SEQ_IDLE;
                  st_d.main.run = 1'b0;
               end else begin
                  st_d.mpass = st_q.mpass + 4'h1;
               end
            end
         end
         default: begin
            st_d.mseq     = atrc_pkg::SEQ_IDLE;
            st_d.main.run = 1'b0;
         end
      endcase

      // a start write latches the settings; a stop mode halts both converters
      if (wr_main_go) begin
         st_d.main.mode          = atrc_pkg::atrc_mode_t'(wbyte[1:0]);
         st_d.main.cs_time       = wbyte[6:5];
         st_d.main.shunt_filt_en = wbyte[4];
         st_d.main.cell_filt_en  = wbyte[3];
         st_d.main.cell_cut      = atrc_eff_cut(st_q.filt[2:0]);
         st_d.main.shunt_cut     = atrc_eff_cut(st_q.filt[5:3]);
         st_d.mpass              = 4'h0;
         if (wbyte[1:0] == atrc_pkg::MODE_SINGLE || wbyte[1:0] == atrc_pkg::MODE_CONT) begin
            st_d.main.run = 1'b1;
            if (atrc_dly_cyc(st_q.dly[5:0]) == 16'h0000) begin
               st_d.mseq            = atrc_pkg::SEQ_RUN;
               st_d.main.conv_start = 1'b1;
               st_d.cs_cnt          = atrc_cs_reload(wbyte[6:5]);
            end else begin
               st_d.mseq    = atrc_pkg::SEQ_DELAY;
               st_d.dly_cnt = atrc_dly_cyc(st_q.dly[5:0]) - 16'h0001;
            end
         end else begin
            st_d.mseq            = atrc_pkg::SEQ_IDLE;
            st_d.main.run        = 1'b0;
            st_d.main.conv_start = 1'b0;
         end
      end

      // aux pass counting; continuous mode never ends by itself
      if (st_q.aux.run && aux_pass_done_i) begin
         if ((st_q.aux.mode == atrc_pkg::MODE_SINGLE
              && st_q.apass == atrc_pkg::AUX_PASSES_1 - 4'h1)
             || (st_q.aux.mode == atrc_pkg::MODE_ALT
              && st_q.apass == atrc_pkg::AUX_PASSES_8 - 4'h1)) begin
            st_d.aux.run = 1'b0;
         end else begin
            st_d.apass = st_q.apass + 4'h1;
         end
      end

      // aux start latches channel selection and mode
      if (wr_aux_go) begin
         st_d.aux.mode     = atrc_pkg::atrc_mode_t'(wbyte[1:0]);
         st_d.aux.gpio_sel = wbyte[6:3];
         st_d.aux.cell_sel = st_q.ach[4:0];
         st_d.aux.align    = st_q.ach[atrc_pkg::ALIGN_BIT];
         st_d.apass        = 4'h0;
         st_d.aux.run      = (wbyte[1:0] != atrc_pkg::MODE_STOP);
         st_d.aux.start    = (wbyte[1:0] != atrc_pkg::MODE_STOP);
      end

      // slot enables follow the live cell count and pin configuration
      if (st_q.aux.cell_sel == atrc_pkg::CELL_ALL
          || st_q.aux.cell_sel == atrc_pkg::CELL_NOSHUNT) begin
         st_d.aux.cell_slot_en = (active_cell_count_i != 5'h00);
      end else if (st_q.aux.cell_sel <= atrc_pkg::CELL_LAST) begin
         st_d.aux.cell_slot_en = (st_q.aux.cell_sel - 5'h01) <= active_cell_count_i;
      end else begin
         st_d.aux.cell_slot_en = 1'b0;
      end
      st_d.aux.shunt_connect = (st_q.aux.cell_sel != atrc_pkg::CELL_NOSHUNT);
      if (st_q.aux.gpio_sel == atrc_pkg::GPIO_ALL) begin
         st_d.aux.gpio_slot_en = |gpio_adc_cfg_i;
      end else if (st_q.aux.gpio_sel <= atrc_pkg::GPIO_LAST) begin
         st_d.aux.gpio_slot_en = gpio_adc_cfg_i[3'(st_q.aux.gpio_sel - 4'h1)];
      end else begin
         st_d.aux.gpio_slot_en = 1'b0;
      end
   end

   // reload value for the currently latched time select
   function automatic logic [20:0] atrc_sel_reload();
      atrc_sel_reload = atrc_cs_reload(st_q.main.cs_time);
   endfunction : atrc_sel_reload

   // ===========================================================
   // state register
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st_q           <= '0;
         st_q.load_pend <= 1'b1;
         st_q.mseq      <= atrc_pkg::SEQ_IDLE;
      end else begin
         st_q <= st_d;
      end
   end

   assign wb_ack_o = st_q.ack;
   assign wb_dat_o = st_q.dat;
   assign trim_o   = st_q.trim;
   assign main_o   = st_q.main;
   assign aux_o    = st_q.aux;

   // ===========================================================
   // assertions
   default clocking atrc_cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);

   AST_TRIM_LOAD: assert property (
      st_q.load_pend |=> (trim_o == $past(otp_trim_i)))
      else $error("trim not loaded after reset");

   AST_GO_READS_ZERO: assert property (
      (req && !wb_we_i && !st_q.ack && idx == atrc_pkg::IDX_MAIN_CTRL)
      |=> (wb_ack_o && !wb_dat_o[atrc_pkg::MAIN_GO_BIT]))
      else $error("main start bit read back as one");

   AST_RSVD_ZERO: assert property (
      wb_ack_o |-> (wb_dat_o[31:8] == 24'h000000))
      else $error("reserved read bits not zero");

   AST_MAIN_HOLD: assert property (
      (wr && idx == atrc_pkg::IDX_MAIN_CTRL && !wbyte[atrc_pkg::MAIN_GO_BIT])
      |=> ($stable(main_o.mode) && $stable(main_o.cs_time) && $stable(main_o.cell_filt_en)))
      else $error("main settings changed without start");

   AST_NO_DELAY: assert property (
      (wr_main_go && wbyte[1:0] == atrc_pkg::MODE_SINGLE && st_q.dly[5:0] == 6'h00)
      |=> main_o.conv_start)
      else $error("zero delay start not immediate");

   AST_DELAY_WAIT: assert property (
      (st_q.mseq == atrc_pkg::SEQ_DELAY && st_q.dly_cnt != 16'h0000 && !wr_main_go)
      |=> !main_o.conv_start)
      else $error("conversion started during delay");

   AST_SINGLE_STOP: assert property (
      (st_q.mseq == atrc_pkg::SEQ_RUN && main_o.mode == atrc_pkg::MODE_SINGLE
       && st_q.mpass == 4'h7 && main_pass_done_i && !wr_main_go)
      |=> (!main_o.run ##1 !main_o.run))
      else $error("single run did not stop after eight passes");

   AST_AUX_EIGHT: assert property (
      (aux_o.run && aux_o.mode == atrc_pkg::MODE_ALT && st_q.apass == 4'h7
       && aux_pass_done_i && !wr_aux_go) |=> !aux_o.run)
      else $error("aux eight-pass run did not stop");

   AST_AUX_HOLD: assert property (
      (wr && idx == atrc_pkg::IDX_AUX_CH) |=> $stable(aux_o.cell_sel))
      else $error("aux channel changed without start");

   AST_GPIO_SKIP: assert property (
      (aux_o.gpio_sel > atrc_pkg::GPIO_LAST && $stable(aux_o.gpio_sel)) |-> !aux_o.gpio_slot_en)
      else $error("reserved pin slot not skipped");

   AST_CUT_ALIAS: assert property (
      main_o.cell_cut != atrc_pkg::CUT_ALIAS && main_o.shunt_cut != atrc_pkg::CUT_ALIAS)
      else $error("alias cut-off code passed to filter");

endmodule : atrc_top

// file: shared/atrc_pkg.sv
// register map, timing constants and carrier types for converter trim and run control
package atrc_pkg;
   localparam int unsigned CLK_PERIOD_NS = 10;
   localparam int unsigned WB_ADR_W      = 16;
   // register indices, byte address is four times the index
   localparam logic [13:0] IDX_FILT_CFG    = 14'h0007;
   localparam logic [13:0] IDX_DLY_CFG     = 14'h0008;
   localparam logic [13:0] IDX_AUX_TRIM_LO = 14'h001d;
   localparam logic [13:0] IDX_AUX_TRIM_HI = 14'h001e;
   localparam logic [13:0] IDX_CS_TRIM_LO  = 14'h001f;
   localparam logic [13:0] IDX_CS_TRIM_HI  = 14'h0020;
   localparam logic [13:0] IDX_MAIN_CTRL   = 14'h030d;
   localparam logic [13:0] IDX_AUX_CH      = 14'h030e;
   localparam logic [13:0] IDX_AUX_RUN     = 14'h030f;
   localparam logic [13:0] IDX_STATUS      = 14'h0310;
   localparam logic [7:0]  REG_RESET       = 8'h00;
   // writable bit masks, everything else reserved
   localparam logic [7:0]  MASK_FILT = 8'h3f;
   localparam logic [7:0]  MASK_DLY  = 8'h3f;
   localparam logic [7:0]  MASK_MAIN = 8'h7b;
   localparam logic [7:0]  MASK_ACH  = 8'h3f;
   localparam logic [7:0]  MASK_ARUN = 8'h7b;
   // field positions
   localparam int unsigned MAIN_GO_BIT   = 2;
   localparam int unsigned AUX_GO_BIT    = 2;
   localparam int unsigned ALIGN_BIT     = 5;
   localparam int unsigned SHUNT_CUT_LSB = 3;
   // start delay
   localparam int unsigned DLY_STEP_US   = 5;
   localparam int unsigned DLY_STEP_CYC  = (DLY_STEP_US * 1000) / CLK_PERIOD_NS;
   localparam logic [5:0]  DLY_MAX_CODE  = 6'h28;
   // current converter measurement times
   localparam int unsigned CS_T0_US  = 768;
   localparam int unsigned CS_T1_US  = 1536;
   localparam int unsigned CS_T2_US  = 3072;
   localparam int unsigned CS_T3_US  = 12288;
   localparam int unsigned CS_T0_CYC = (CS_T0_US * 1000) / CLK_PERIOD_NS;
   localparam int unsigned CS_T1_CYC = (CS_T1_US * 1000) / CLK_PERIOD_NS;
   localparam int unsigned CS_T2_CYC = (CS_T2_US * 1000) / CLK_PERIOD_NS;
   localparam int unsigned CS_T3_CYC = (CS_T3_US * 1000) / CLK_PERIOD_NS;
   // pass counts and select codes
   localparam logic [3:0]  MAIN_PASSES  = 4'h8;
   localparam logic [3:0]  AUX_PASSES_1 = 4'h1;
   localparam logic [3:0]  AUX_PASSES_8 = 4'h8;
   localparam logic [4:0]  CELL_ALL     = 5'h00;
   localparam logic [4:0]  CELL_NOSHUNT = 5'h01;
   localparam logic [4:0]  CELL_FIRST   = 5'h02;
   localparam logic [4:0]  CELL_LAST    = 5'h11;
   localparam logic [3:0]  GPIO_ALL     = 4'h0;
   localparam logic [3:0]  GPIO_LAST    = 4'h8;
   localparam logic [2:0]  CUT_ALIAS    = 3'h7;
   localparam logic [2:0]  CUT_ALIAS_TO = 3'h5;

   typedef enum logic [1:0] {
      MODE_STOP = 2'b00, MODE_SINGLE = 2'b01, MODE_CONT = 2'b10, MODE_ALT = 2'b11
   } atrc_mode_t;
   typedef enum logic [1:0] {
      SEQ_IDLE = 2'b00, SEQ_DELAY = 2'b01, SEQ_RUN = 2'b10
   } atrc_seq_t;

   typedef struct packed {
      logic [8:0]  aux_gain;
      logic [6:0]  aux_offset;
      logic [10:0] cs_gain;
      logic [4:0]  cs_offset;
   } atrc_trim_t;

   typedef struct packed {
      logic       run;
      logic       conv_start;
      logic       cs_sample;
      atrc_mode_t mode;
      logic [1:0] cs_time;
      logic       cell_filt_en;
      logic       shunt_filt_en;
      logic [2:0] cell_cut;
      logic [2:0] shunt_cut;
   } atrc_main_t;

   typedef struct packed {
      logic       run;
      logic       start;
      atrc_mode_t mode;
      logic [4:0] cell_sel;
      logic       align;
      logic       cell_slot_en;
      logic       shunt_connect;
      logic [3:0] gpio_sel;
      logic       gpio_slot_en;
   } atrc_aux_t;
endpackage : atrc_pkg

// file: verif/atrc_tb.sv
// self-checking bench for converter trim and run control
`timescale 1ns/1ps
module tb;
   logic                 clk_i, rst_i, cyc, stb, we, mpd, apd;
   logic [15:0]          adr;
   logic [31:0]          dat, wb_dat_o;
   logic                 wb_ack_o;
   logic [4:0]           cells;
   logic [7:0]           pins, rd;
   logic [3:0]           sel, wsel;
   atrc_pkg::atrc_trim_t otp, trim_o;
   atrc_pkg::atrc_main_t main_o;
   atrc_pkg::atrc_aux_t  aux_o;
   int                   errors, tests_run, n;
   // delay step shortened so the start delay is a few cycles
   atrc_top #(.DLY_STEP_CYC(2), .CS_T0_CYC(10), .CS_T1_CYC(20), .CS_T2_CYC(30),
      .CS_T3_CYC(40)) uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(wb_dat_o),
      .wb_ack_o(wb_ack_o), .otp_trim_i(otp), .main_pass_done_i(mpd), .aux_pass_done_i(apd),
      .active_cell_count_i(cells), .gpio_adc_cfg_i(pins), .trim_o(trim_o), .main_o(main_o),
      .aux_o(aux_o));
   initial begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end
   // ==========================================
   // shared tasks
   task automatic close_out();
      $display("counts: %0d compared, %0d mismatched", tests_run, errors);
      if (errors == 0 && tests_run > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : close_out
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         errors++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask : chk
   // classic cycle, held until ack is seen, data taken in the ack cycle
   task automatic wb(input logic w, input logic [13:0] idx, input logic [7:0] d);
      int k;
      @(posedge clk_i);
      cyc <= 1'b1;
      stb <= 1'b1;
      we  <= w;
      sel <= wsel;
      adr <= {idx, 2'b00};
      dat <= {24'h0, d};
      k = 0;
      // ack is read before the edge updates it, so this is its sampled value
      do begin @(posedge clk_i); k++; end while (wb_ack_o !== 1'b1 && k < 20);
      if (k >= 20) begin errors++; close_out(); end
      rd = wb_dat_o[7:0];
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask : wb
   task automatic pulse_main(input int c);
      repeat (c) begin @(posedge clk_i) mpd <= 1'b1; @(posedge clk_i) mpd <= 1'b0; end
      repeat (2) @(negedge clk_i);
   endtask : pulse_main
   task automatic pulse_aux(input int c);
      repeat (c) begin @(posedge clk_i) apd <= 1'b1; @(posedge clk_i) apd <= 1'b0; end
      repeat (2) @(negedge clk_i);
   endtask : pulse_aux
   // ==========================================
   // scenarios
   task automatic t_trim();
      chk(trim_o, otp);
      wb(0, atrc_pkg::IDX_AUX_TRIM_LO, 0); chk(rd, otp[30:23]);
      // a write without its byte lane is acked but must not land
      wsel = 4'h0; wb(1, atrc_pkg::IDX_AUX_TRIM_LO, 8'h3c); wsel = 4'h1;
      wb(0, atrc_pkg::IDX_AUX_TRIM_LO, 0); chk(rd, otp[30:23]);
      wb(0, atrc_pkg::IDX_MAIN_CTRL, 0); chk(rd, 8'h00);
      wb(1, atrc_pkg::IDX_AUX_TRIM_HI, 8'haa); @(negedge clk_i);
      chk({trim_o.aux_gain[8], trim_o.aux_offset}, 8'haa);
      wb(1, atrc_pkg::IDX_CS_TRIM_HI, 8'hb3); @(negedge clk_i);
      chk({trim_o.cs_gain[10:8], trim_o.cs_offset}, 8'hb3);
      wb(1, atrc_pkg::IDX_AUX_CH, 8'hff); wb(0, atrc_pkg::IDX_AUX_CH, 0);
      chk(rd, 8'h3f);
      $display("test trim done");
   endtask : t_trim
   task automatic t_main();
      wb(1, atrc_pkg::IDX_MAIN_CTRL, 8'h1d); @(negedge clk_i);
      chk({main_o.run, main_o.mode}, 3'h5);
      chk({main_o.cell_filt_en, main_o.shunt_filt_en}, 2'h3);
      wb(1, atrc_pkg::IDX_MAIN_CTRL, 8'h62); wb(0, atrc_pkg::IDX_MAIN_CTRL, 0);
      chk(rd[2], 1'b0);
      chk({main_o.mode, main_o.cs_time}, 4'h4);
      pulse_main(7); chk(main_o.run, 1'b1);
      pulse_main(1); chk(main_o.run, 1'b0);
      wb(1, atrc_pkg::IDX_MAIN_CTRL, 8'h66); @(negedge clk_i);
      chk({main_o.run, main_o.mode, main_o.cs_time}, 5'h1b);
      pulse_main(9); chk(main_o.run, 1'b1);
      wb(1, atrc_pkg::IDX_MAIN_CTRL, 8'h04); @(negedge clk_i);
      chk(main_o.run, 1'b0);
      $display("test main done");
   endtask : t_main
   task automatic t_delay(input logic [5:0] code, input int exp);
      wb(1, atrc_pkg::IDX_DLY_CFG, {2'b00, code});
      wb(1, atrc_pkg::IDX_MAIN_CTRL, 8'h05);
      n = 0;
      @(negedge clk_i);
      while (main_o.conv_start !== 1'b1 && n < 100) begin @(negedge clk_i); n++; end
      chk(n, exp);
      @(negedge clk_i);
      chk(main_o.conv_start, 1'b0);
      wb(1, atrc_pkg::IDX_MAIN_CTRL, 8'h04);
      $display("test delay done");
   endtask : t_delay
   task automatic t_aux(input logic [4:0] c, input logic [3:0] p, input logic [1:0] e);
      wb(1, atrc_pkg::IDX_AUX_CH, {3'b001, c});
      wb(1, atrc_pkg::IDX_AUX_RUN, {1'b0, p, 3'b101});
      @(negedge clk_i);
      chk(aux_o.start, 1'b1);
      @(negedge clk_i);
      chk(aux_o.start, 1'b0);
      chk({aux_o.run, aux_o.align, aux_o.cell_sel}, {2'b11, c});
      chk({aux_o.mode, aux_o.gpio_sel}, {2'b01, p});
      chk(aux_o.shunt_connect, c != 5'h01);
      chk({aux_o.cell_slot_en, aux_o.gpio_slot_en}, e);
      wb(0, atrc_pkg::IDX_AUX_RUN, 0); chk(rd, {1'b0, p, 3'b001});
      @(posedge clk_i) apd <= 1'b1; @(posedge clk_i) apd <= 1'b0;
      repeat (2) @(negedge clk_i); chk(aux_o.run, 1'b0);
      $display("test aux done");
   endtask : t_aux
   // code 7 must reach the filter as the 240 Hz setting; later edits must not leak in
   task automatic t_filt();
      wb(1, atrc_pkg::IDX_FILT_CFG, 8'hf7); wb(0, atrc_pkg::IDX_FILT_CFG, 0);
      chk(rd, 8'h37);
      wb(1, atrc_pkg::IDX_MAIN_CTRL, 8'h1d); wb(1, atrc_pkg::IDX_FILT_CFG, 8'h00);
      @(negedge clk_i);
      chk({main_o.cell_cut, main_o.shunt_cut}, 6'h2e);
      wb(1, atrc_pkg::IDX_MAIN_CTRL, 8'h04);
      $display("test filter done");
   endtask : t_filt
   // current converter pacing, measured from the start pulse and then sample to sample
   task automatic t_cs(input logic [1:0] ts, input int exp);
      wb(1, atrc_pkg::IDX_MAIN_CTRL, {1'b0, ts, 5'b00110});
      n = 0;
      @(negedge clk_i);
      chk(main_o.conv_start, 1'b1);
      while (main_o.cs_sample !== 1'b1 && n < 100) begin @(negedge clk_i); n++; end
      chk(n, exp);
      n = 0;
      do begin @(negedge clk_i); n++; end while (main_o.cs_sample !== 1'b1 && n < 100);
      chk(n, exp);
      wb(1, atrc_pkg::IDX_MAIN_CTRL, 8'h07); @(negedge clk_i);
      chk(main_o.run, 1'b0);
      $display("test current timer done");
   endtask : t_cs
   // eight-pass and continuous aux modes
   task automatic t_aux_run();
      wb(1, atrc_pkg::IDX_AUX_RUN, 8'h07);
      pulse_aux(7); chk(aux_o.run, 1'b1);
      pulse_aux(1); chk(aux_o.run, 1'b0);
      wb(1, atrc_pkg::IDX_AUX_RUN, 8'h06);
      pulse_aux(9); chk(aux_o.run, 1'b1);
      wb(1, atrc_pkg::IDX_AUX_RUN, 8'h04); @(negedge clk_i);
      chk({aux_o.run, aux_o.start}, 2'b00);
      $display("test aux run done");
   endtask : t_aux_run
   // reset with every converter stopped: registers clear and the new fused trim is taken
   task automatic t_reset();
      @(posedge clk_i);
      rst_i <= 1'b1;
      otp   <= 32'h1e2d3c4b;
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      repeat (2) @(negedge clk_i);
      chk(trim_o, otp);
      chk(main_o, 32'h0);
      wb(0, atrc_pkg::IDX_DLY_CFG, 0); chk(rd, 8'h00);
      $display("test reset done");
   endtask : t_reset
   // ==========================================
   // main sequence
   initial begin
      rst_i = 1'b1; cyc = 1'b0; stb = 1'b0; we = 1'b0; adr = 16'h0; dat = 32'h0;
      mpd = 1'b0; apd = 1'b0; cells = 5'h04; pins = 8'h04; otp = 32'ha5b3c7d9;
      errors = 0; tests_run = 0; sel = 4'h1; wsel = 4'h1;
      repeat (8) @(posedge clk_i);
      rst_i <= 1'b0;
      repeat (2) @(negedge clk_i);
      t_trim();
      t_main();
      t_filt();
      t_delay(6'h03, 6);
      t_delay(6'h29, 0);
      t_cs(2'b00, 10);
      t_cs(2'b11, 40);
      t_aux(5'h12, 4'h3, 2'b01);
      t_aux(5'h05, 4'h2, 2'b10);
      t_aux(5'h06, 4'h9, 2'b00);
      t_aux(5'h01, 4'h0, 2'b11);
      t_aux_run();
      t_reset();
      close_out();
   end
endmodule : tb
